// file: src/stack_fault_defs.svh
`ifndef STACK_FAULT_DEFS_SVH
`define STACK_FAULT_DEFS_SVH

// return-address stack geometry
`define STK_DEPTH 31
`define STK_PTR_W 5
`define STK_PTR_EMPTY 5'h00
`define STK_PTR_FULL 5'h1f
`define STK_PTR_STEP 5'h01
`define ADDR_W 16
`define REG_W 8
// value seen on the pop port when a pop finds the stack empty
`define POP_EMPTY_ADDR 16'h0000
// reset value of every context register
`define CTX_RESET 8'h00

`endif

// file: src/stack_fault_pkg.sv
package stack_fault_pkg;
  `include "stack_fault_defs.svh"

  typedef struct packed {
    logic [`REG_W-1:0] status;
    logic [`REG_W-1:0] working_register;
    logic [`REG_W-1:0] bank_select_register;
  } ctx_s;

  // one request per cycle from the sequencer
  typedef struct packed {
    logic call;
    logic ret;
    logic return_from_interrupt_instr;
    logic vector;
    logic fast;
    logic [`ADDR_W-1:0] pc;
  } seq_req_s;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_FAULT = 2'b10
  } fault_st_e;

  typedef struct packed {
    fault_st_e fsm;
    logic [`STK_PTR_W-1:0] ptr;
    logic [`STK_DEPTH-1:0][`ADDR_W-1:0] ras;
    logic stack_full_flag;
    logic stack_empty_pop_flag;
    logic device_reset_req;
    logic restore_valid;
    ctx_s restore_ctx;
    logic pop_valid;
    logic [`ADDR_W-1:0] pop_addr;
  } core_state_s;

  function automatic logic stk_full(input logic [`STK_PTR_W-1:0] ptr);
    return ptr == `STK_PTR_FULL;
  endfunction

  function automatic logic stk_empty(input logic [`STK_PTR_W-1:0] ptr);
    return ptr == `STK_PTR_EMPTY;
  endfunction
endpackage

// file: src/shadow_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "stack_fault_defs.svh"
// single-entry shadow, no read or write path from instructions
module shadow_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire stack_fault_pkg::ctx_s d,
  output stack_fault_pkg::ctx_s q
);
  import stack_fault_pkg::*;

  ctx_s st;
  ctx_s next_st;

  always_comb begin
    next_st = st;
    if (load) begin
      next_st = d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '{`CTX_RESET, `CTX_RESET, `CTX_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign q = st;
endmodule // shadow_regs
`default_nettype wire

// file: src/stack_fault_and_fast_context_save.sv
`timescale 1ns/1ns
`default_nettype none
`include "stack_fault_defs.svh"
// What this block does
// - with fault reset enabled, overflow or underflow sets its flag, then requests reset.
// - with fault reset disabled, overflow or underflow sets its flag only.
// - fault flags hold until software clears them or power-on reset.
// - one hidden shadow copy each of status, working and bank select.
// - interrupt vectoring copies current status, working and bank select into shadow.
// - every interrupt priority captures, so nested high overwrites low-level save.
// - fast interrupt return restores shadow values; plain interrupt return restores nothing.
// - fast call saves context into shadow besides pushing return address.
// - fast return restores context from shadow besides popping return address.
// - shadow is unreliable across low priority service when both priorities used.
module stack_fault_and_fast_context_save (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stack_fault_reset_enable,
  input wire stack_fault_pkg::seq_req_s req,
  input wire stack_fault_pkg::ctx_s cur_ctx,
  input wire logic clr_stack_full_flag,
  input wire logic clr_stack_empty_pop_flag,
  output logic stack_full_flag,
  output logic stack_empty_pop_flag,
  output logic device_reset_req,
  output logic restore_valid,
  output stack_fault_pkg::ctx_s restore_ctx,
  output logic pop_valid,
  output logic [`ADDR_W-1:0] pop_addr
);
  import stack_fault_pkg::*;

  core_state_s st;
  core_state_s next_st;
  ctx_s shadow_q;
  logic push;
  logic pop;
  logic overflow;
  logic underflow;
  logic capture;

  assign push = req.call | req.vector;
  assign pop = req.ret | req.return_from_interrupt_instr;
  assign overflow = push && stk_full(st.ptr);
  assign underflow = pop && stk_empty(st.ptr);
  // every vector reloads the shadow, nothing guards a low-level save
  // from a nested high-level entry; software must save its own context
  assign capture = req.vector | (req.call & req.fast);

  shadow_regs u_shadow (
    .clk(clk),
    .rst_b(rst_b),
    .load(capture),
    .d(cur_ctx),
    .q(shadow_q)
  );

  always_comb begin
    next_st = st;
    next_st.device_reset_req = 1'b0;
    next_st.restore_valid = 1'b0;
    next_st.pop_valid = 1'b0;
    // a push on a full stack is dropped so older entries survive
    if (push && !overflow) begin
      next_st.ras[st.ptr] = req.pc;
      next_st.ptr = st.ptr + `STK_PTR_STEP;
    end
    if (pop) begin
      next_st.pop_valid = 1'b1;
      if (underflow) begin
        next_st.pop_addr = `POP_EMPTY_ADDR;
      end else begin
        next_st.pop_addr = st.ras[st.ptr - `STK_PTR_STEP];
        next_st.ptr = st.ptr - `STK_PTR_STEP;
      end
      if (req.fast) begin
        next_st.restore_valid = 1'b1;
        next_st.restore_ctx = shadow_q;
      end
    end
    // set beats a same-cycle clear so no fault is lost
    if (clr_stack_full_flag) begin
      next_st.stack_full_flag = 1'b0;
    end
    if (overflow) begin
      next_st.stack_full_flag = 1'b1;
    end
    if (clr_stack_empty_pop_flag) begin
      next_st.stack_empty_pop_flag = 1'b0;
    end
    if (underflow) begin
      next_st.stack_empty_pop_flag = 1'b1;
    end
    case (st.fsm)
      ST_RUN: begin
        // flag lands first, reset request one cycle later
        if ((overflow || underflow) && stack_fault_reset_enable) begin
          next_st.fsm = ST_FAULT;
        end
      end
      ST_FAULT: begin
        next_st.device_reset_req = 1'b1;
        next_st.fsm = ST_RUN;
      end
      default: begin
        next_st.fsm = ST_RUN;
      end
    endcase
  end

  // rst_b is the power-on reset; the fault reset leaves this block alone
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
      st.fsm <= ST_RUN;
    end else begin
      st <= next_st;
    end
  end

  assign stack_full_flag = st.stack_full_flag;
  assign stack_empty_pop_flag = st.stack_empty_pop_flag;
  assign device_reset_req = st.device_reset_req;
  assign restore_valid = st.restore_valid;
  assign restore_ctx = st.restore_ctx;
  assign pop_valid = st.pop_valid;
  assign pop_addr = st.pop_addr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_overflow_flag_set: assert property (
    overflow |=> stack_full_flag
  ) else $error("overflow did not set full flag");

  chk_underflow_flag_set: assert property (
    underflow |=> stack_empty_pop_flag && pop_valid && pop_addr == `POP_EMPTY_ADDR
  ) else $error("underflow did not set empty pop flag");

  chk_fault_then_reset: assert property (
    (overflow || underflow) && stack_fault_reset_enable && st.fsm == ST_RUN
      |=> !device_reset_req ##1 device_reset_req
  ) else $error("fault reset not one cycle after flag");

  chk_no_fault_reset: assert property (
    (overflow || underflow) && !stack_fault_reset_enable && st.fsm == ST_RUN
      |=> !device_reset_req ##1 !device_reset_req
  ) else $error("reset raised with fault reset disabled");

  chk_flag_sticky: assert property (
    stack_full_flag && !clr_stack_full_flag |=> stack_full_flag
  ) else $error("full flag dropped without clear");

  chk_set_beats_clear: assert property (
    underflow && clr_stack_empty_pop_flag |=> stack_empty_pop_flag
  ) else $error("clear beat a same-cycle underflow");

  chk_vector_capture: assert property (
    req.vector |=> shadow_q == $past(cur_ctx)
  ) else $error("vector did not capture context");

  chk_nested_overwrite: assert property (
    req.vector ##[1:8] req.vector |=> shadow_q == $past(cur_ctx)
  ) else $error("nested vector did not overwrite shadow");

  chk_fast_irq_return: assert property (
    req.return_from_interrupt_instr && req.fast
      |=> restore_valid && restore_ctx == $past(shadow_q)
  ) else $error("fast interrupt return did not restore");

  chk_slow_no_restore: assert property (
    pop && !req.fast |=> !restore_valid
  ) else $error("restore without fast option");

  chk_fast_call_save: assert property (
    req.call && req.fast |=> shadow_q == $past(cur_ctx) && st.ptr != $past(st.ptr)
      || $past(overflow)
  ) else $error("fast call did not save context");

  chk_fast_ret_restore: assert property (
    req.ret && req.fast && !stk_empty(st.ptr)
      |=> restore_valid && restore_ctx == $past(shadow_q) && pop_valid
  ) else $error("fast return did not restore");

  chk_reset_one_cycle: assert property (
    device_reset_req |=> !device_reset_req
  ) else $error("device reset request longer than one cycle");

  chk_reset_needs_enable: assert property (
    device_reset_req |-> $past(stack_fault_reset_enable, 2)
  ) else $error("device reset requested while fault reset disabled");

  chk_full_clear: assert property (
    clr_stack_full_flag && !overflow |=> !stack_full_flag
  ) else $error("full flag not cleared by software clear");

  chk_empty_clear: assert property (
    clr_stack_empty_pop_flag && !underflow |=> !stack_empty_pop_flag
  ) else $error("empty pop flag not cleared by software clear");

  chk_pop_keeps_shadow: assert property (
    pop |=> $stable(shadow_q)
  ) else $error("shadow changed on a pop");

  chk_plain_call_keep: assert property (
    req.call && !req.fast && !req.vector |=> $stable(shadow_q)
  ) else $error("plain call changed the shadow");

  cov_overflow_reset: cover property (
    overflow && stack_fault_reset_enable ##2 device_reset_req
  );
  cov_fast_call_return: cover property (
    req.call && req.fast ##[1:20] req.ret && req.fast
  );
  cov_vector_fast_return: cover property (
    req.vector ##[1:20] req.return_from_interrupt_instr && req.fast
  );
  cov_underflow_no_reset: cover property (
    underflow && !stack_fault_reset_enable
  );
  cov_set_beats_clear: cover property (
    underflow && clr_stack_empty_pop_flag
  );
endmodule // stack_fault_and_fast_context_save
`default_nettype wire

// file: test/seq_model.sv
`timescale 1ns/1ns
`default_nettype none
// core side: owns the live context and takes restores back
module seq_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire stack_fault_pkg::ctx_s load_ctx,
  input wire logic restore_valid,
  input wire stack_fault_pkg::ctx_s restore_ctx,
  output stack_fault_pkg::ctx_s cur_ctx
);
  import stack_fault_pkg::*;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur_ctx <= '0;
    end else if (restore_valid) begin
      cur_ctx <= restore_ctx;
    end else if (load) begin
      cur_ctx <= load_ctx;
    end
  end
endmodule // seq_model
`default_nettype wire

// file: test/stack_fault_and_fast_context_save_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "stack_fault_defs.svh"
module stack_fault_and_fast_context_save_bench;
  import stack_fault_pkg::*;
  logic clk, rst_b, en, clr_f, clr_e, ld, ff, ef, dr, rv, pv;
  seq_req_s req;
  ctx_s cur_ctx, ld_ctx, rctx;
  logic [`ADDR_W-1:0] pa;
  int fails = 0;
  int compares = 0;
  int resets = 0;

  stack_fault_and_fast_context_save stack_fault_and_fast_context_save_i (
    .clk(clk), .rst_b(rst_b), .stack_fault_reset_enable(en), .req(req),
    .cur_ctx(cur_ctx), .clr_stack_full_flag(clr_f), .clr_stack_empty_pop_flag(clr_e),
    .stack_full_flag(ff), .stack_empty_pop_flag(ef), .device_reset_req(dr),
    .restore_valid(rv), .restore_ctx(rctx), .pop_valid(pv), .pop_addr(pa));
  seq_model seq_model_i (.clk(clk), .rst_b(rst_b), .load(ld), .load_ctx(ld_ctx),
    .restore_valid(rv), .restore_ctx(rctx), .cur_ctx(cur_ctx));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pulses are one cycle wide, so count them rather than sample once
  always @(posedge clk) begin
    if (dr === 1'b1) resets++;
  end

  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic go(logic c, r, i, v, f, logic [15:0] pc);
    @(posedge clk);
    req <= '{c, r, i, v, f, pc};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic setc(logic [23:0] c);
    @(posedge clk);
    ld <= 1'b1;
    ld_ctx <= c;
    @(posedge clk);
    ld <= 1'b0;
  endtask

  task automatic fast_call;
    setc(24'h12_3456);
    go(1, 0, 0, 0, 1, 16'h0abc);
    setc(24'h00_0000);
    go(0, 1, 0, 0, 1, 16'h0000);
    chk("pop_addr", 24'h01_0abc, {7'h00, pv, pa});
    chk("fast ret", 24'h12_3456, rv ? rctx : 24'h00_0000);
    @(posedge clk);
    #1;
    chk("core ctx", 24'h12_3456, cur_ctx);
  endtask
  task automatic nested_irq;
    setc(24'h11_1111);
    go(0, 0, 0, 1, 0, 16'h0100);
    setc(24'h22_2222);
    go(0, 0, 0, 1, 0, 16'h0200);
    setc(24'h33_3333);
    go(0, 0, 1, 0, 1, 16'h0000);
    chk("fast rfi", 24'h22_2222, rv ? rctx : 24'h00_0000);
    chk("rfi addr", 24'h00_0200, {8'h00, pa});
    go(0, 0, 1, 0, 0, 16'h0000);
    chk("plain rfi", 24'h00_0001, {23'h0, pv & ~rv});
  endtask
  task automatic underflow;
    @(posedge clk);
    en <= 1'b0;
    go(0, 1, 0, 0, 0, 16'h0000);
    chk("empty pop", 24'h01_0000, {7'h00, pv, pa});
    chk("unf flag", 24'h00_0001, {23'h0, ef});
    repeat (4) @(posedge clk);
    #1;
    chk("unf quiet", 24'h00_0100, {15'h0, ef, 8'(resets)});
    @(posedge clk);
    clr_e <= 1'b1;
    @(posedge clk);
    clr_e <= 1'b0;
    #1;
    chk("unf clear", 24'h00_0000, {23'h0, ef});
  endtask
  // empty pop with fault reset on, while software clears the same flag
  task automatic empty_fault;
    @(posedge clk);
    en <= 1'b1;
    clr_e <= 1'b1;
    req <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000};
    @(posedge clk);
    clr_e <= 1'b0;
    req <= '0;
    #1;
    chk("unf vs clear", 24'h00_0001, {23'h0, ef});
    @(posedge clk);
    #1;
    chk("unf reset", 24'h00_0001, {23'h0, dr});
    @(posedge clk);
    #1;
    chk("reset width", 24'h00_0000, {23'h0, dr});
  endtask
  task automatic overflow;
    @(posedge clk);
    en <= 1'b1;
    // the 31 pushes fill the stack exactly, the extra one faults
    for (int k = 0; k < 32; k++) go(1, 0, 0, 0, 0, 16'(k));
    chk("ovf flag", 24'h00_0001, {23'h0, ff});
    @(posedge clk);
    #1;
    chk("reset pulse", 24'h00_0001, {23'h0, dr});
    repeat (3) @(posedge clk);
    #1;
    chk("ovf sticky", 24'h00_0102, {15'h0, ff, 8'(resets)});
    @(posedge clk);
    clr_f <= 1'b1;
    clr_e <= 1'b1;
    @(posedge clk);
    clr_f <= 1'b0;
    clr_e <= 1'b0;
    #1;
    chk("ovf clear", 24'h00_0000, {22'h0, ff, ef});
  endtask

  task automatic results;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #8000;
    fails++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    {en, clr_f, clr_e, ld} = '0;
    ld_ctx = '0;
    req = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    fast_call();
    nested_irq();
    underflow();
    empty_fault();
    overflow();
    results();
  end
endmodule // stack_fault_and_fast_context_save_bench
`default_nettype wire
